// file: dv/rfs_partner.sv
// power stage and system monitor model facing the supervisor
`timescale 1ns/100ps
module rfs_partner
(
    // supervisor outputs
    input  wire logic                flag_i,
    input  wire logic                flag_oe_i,
    input  wire rfs_pkg::rfs_drive_t drive_i,
    input  wire logic                drives_off_i,
    // levels seen by the monitor and the stages
    output      logic                ok_level_o,
    output      logic [2:0]          hs_ok_o,
    output      logic [2:0]          ls_on_o
);
    import rfs_pkg::*;
    // open-drain ready line with pull-up: released reads high
    assign ok_level_o = flag_oe_i ? flag_i : 1'b1;
    // stage gates: shutdown wins over the per channel overrides
    assign hs_ok_o = drives_off_i ? 3'h0 : ~drive_i.hs_block;
    assign ls_on_o = drives_off_i ? 3'h0 : drive_i.ls_force;
endmodule

// file: dv/tb_top.sv
// self-checking bench for the regulator fault supervisor
`timescale 1ns/100ps
module tb_top;
    import rfs_pkg::*;
    // ********************
    // signals
    // ********************
    logic        clk_i, reset_i, enable_i, no_cpu_code_i, vid_transition_i;
    logic        ss_active_i, ss_done_i, ss_restart_o, drives_off_o, irq_o;
    logic        flag_o, flag_oe, ok_lvl, wr_i, rd_i;
    logic [2:0]  hs_ok, ls_on;
    logic [3:0]  addr_i;
    logic [31:0] wdata_i, rdata_o, st;
    rfs_sense_t  sense_i;
    rfs_chan_t   chan_i;
    rfs_drive_t  drive_o;
    int          errors, num_checks, restarts;
    // ********************
    // design and partner
    // ********************
    rfs_supervisor dut (.clk_i(clk_i), .reset_i(reset_i),
        .enable_i(enable_i), .no_cpu_code_i(no_cpu_code_i),
        .vid_transition_i(vid_transition_i), .ss_active_i(ss_active_i),
        .ss_done_i(ss_done_i), .ss_restart_o(ss_restart_o),
        .sense_i(sense_i), .chan_i(chan_i), .drive_o(drive_o),
        .drives_off_o(drives_off_o), .regulator_ok_flag_o(flag_o),
        .regulator_ok_flag_oe_o(flag_oe), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .irq_o(irq_o));
    rfs_partner stage (.flag_i(flag_o), .flag_oe_i(flag_oe),
        .drive_i(drive_o), .drives_off_i(drives_off_o),
        .ok_level_o(ok_lvl), .hs_ok_o(hs_ok), .ls_on_o(ls_on));
    // clock at 25 MHz
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // count soft-start restart pulses
    always @(posedge clk_i)
        if (ss_restart_o === 1'b1) restarts++;
    // ********************
    // tasks
    // ********************
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog
    initial
    begin
        repeat (30000) @(posedge clk_i);
        errors++;
        results();
    end
    // ********************
    // tests
    // ********************
    initial
    begin
        {enable_i, no_cpu_code_i, vid_transition_i, ss_active_i} = 4'h0;
        {ss_done_i, wr_i, rd_i, addr_i, wdata_i} = '0;
        sense_i = '0;
        chan_i = '0;
        reset_i = 1'b1;
        cyc(5);
        chk("off_rst", 1, drives_off_o);
        chk("ok_rst", 0, ok_lvl);
        reset_i <= 1'b0;
        rd(REG_STATUS, st);
        chk("phase", 0, st[2:0]);
        rd(4'hC, st);
        chk("unmapped", 0, st);
        // pre-charged start: feedback above reference, then above setpoint
        sense_i.fb_above_ref <= 1'b1;
        enable_i <= 1'b1;
        ss_active_i <= 1'b1;
        cyc(4);
        chk("ss_hold", 1, drives_off_o);
        sense_i.fb_above_ref <= 1'b0;
        cyc(3);
        chk("ss_go", 0, drives_off_o);
        sense_i.above_setpoint <= 1'b1;
        cyc(3);
        chk("pre_hold", 1, drives_off_o);
        chk("ok_ss", 0, ok_lvl);
        ss_done_i <= 1'b1;
        ss_active_i <= 1'b0;
        cyc(1);
        ss_done_i <= 1'b0;
        sense_i.above_setpoint <= 1'b0;
        cyc(3);
        chk("pre_go", 0, drives_off_o);
        cyc(2000);
        chk("ok_wait", 0, ok_lvl);
        cyc(400);
        chk("ok_up", 1, ok_lvl);
        // undervoltage with hysteresis
        sense_i.uv_below_050 <= 1'b1;
        cyc(3);
        chk("uv_ok", 0, ok_lvl);
        chk("uv_drv", 0, drives_off_o);
        sense_i.uv_below_050 <= 1'b0;
        sense_i.uv_above_060 <= 1'b1;
        cyc(2400);
        chk("uv_back", 1, ok_lvl);
        // per channel limit, normal and boosted
        chan_i.over_140 <= 3'h2;
        cyc(3);
        chk("ocl", 6'h12, drive_o);
        vid_transition_i <= 1'b1;
        chan_i.over_140 <= 3'h1;
        sense_i.iavg_100 <= 1'b1;
        cyc(3);
        chk("ocl_bst", 0, drive_o);
        rd(REG_STATUS, st);
        chk("oc_bst", 2, st[2:0]);
        chan_i.over_196 <= 3'h1;
        cyc(3);
        chk("ocl_196", 6'h09, drive_o);
        chan_i <= '0;
        sense_i.iavg_100 <= 1'b0;
        vid_transition_i <= 1'b0;
        cyc(3);
        chan_i.over_140 <= 3'h1;
        cyc(1100);
        chk("ocl_hold", 0, drive_o);
        cyc(300);
        chk("ocl_end", 6'h09, drive_o);
        chan_i <= '0;
        // overvoltage in run with interrupt
        wr(REG_MASK, 32'h0000_0001);
        sense_i.ov_fixed <= 1'b1;
        cyc(3);
        chk("ov_fix", 0, drive_o.ls_force);
        sense_i.ov_dac <= 1'b1;
        cyc(3);
        chk("ov_ls", 7, drive_o.ls_force);
        chk("ov_ok", 0, ok_lvl);
        chk("irq", 1, irq_o);
        sense_i.ov_dac <= 1'b0;
        sense_i.ov_fixed <= 1'b0;
        cyc(3);
        chk("ov_keep", 7, drive_o.ls_force);
        sense_i.ov_dac_low <= 1'b1;
        cyc(3);
        rd(REG_STATUS, st);
        chk("ov_lat", 4, st[2:0]);
        wr(REG_IRQ, 32'h0000_0001);
        cyc(2);
        chk("irq_clr", 0, irq_o);
        // enable toggle clears; soft-start overvoltage once, then twice
        enable_i <= 1'b0;
        sense_i.ov_dac_low <= 1'b0;
        cyc(3);
        rd(REG_STATUS, st);
        chk("en_clr", 0, st[2:0]);
        enable_i <= 1'b1;
        ss_active_i <= 1'b1;
        sense_i.ov_dac <= 1'b1;
        cyc(4);
        chk("ss_lvl", 0, drive_o.ls_force);
        for (int i = 0; i < 2; i++)
        begin
            sense_i.ov_fixed <= 1'b1;
            sense_i.ov_dac <= 1'b1;
            {sense_i.ov_fixed_low, sense_i.ov_dac_low} <= 2'h0;
            cyc(3);
            chk("ss_ov", 7, drive_o.ls_force);
            {sense_i.ov_fixed, sense_i.ov_dac} <= 2'h0;
            {sense_i.ov_fixed_low, sense_i.ov_dac_low} <= 2'h3;
            cyc(3);
            rd(REG_STATUS, st);
            chk("ss_ov_ph", i ? 4 : 1, st[2:0]);
        end
        // overcurrent hiccup and five-attempt latch
        enable_i <= 1'b0;
        {sense_i.ov_fixed_low, sense_i.ov_dac_low} <= 2'h0;
        cyc(3);
        enable_i <= 1'b1;
        cyc(3);
        ss_done_i <= 1'b1;
        cyc(1);
        ss_done_i <= 1'b0;
        cyc(3);
        for (int i = 0; i < 5; i++)
        begin
            restarts = 0;
            rd(REG_STATUS, st);
            chk("oc_nlat", 1, st[2:0] != 4);
            if (i == 0) sense_i.current_monitor_voltage_over <= 1'b1;
            else sense_i.iavg_100 <= 1'b1;
            cyc(2);
            if (i == 0) chk("oc_off", 1, drives_off_o);
            {sense_i.current_monitor_voltage_over, sense_i.iavg_100} <= 2'h0;
            cyc(1);
            chk("oc_ok", 0, ok_lvl);
            cyc(6);
            if (i < 4) chk("oc_retry", 1, restarts);
        end
        rd(REG_STATUS, st);
        chk("oc_lat", 4, st[2:0]);
        chk("oc_cnt", 5, st[9:7]);
        // no-cpu code latches; reset clears
        enable_i <= 1'b0;
        cyc(3);
        rd(REG_STATUS, st);
        chk("oc_clr", 0, st[9:7]);
        enable_i <= 1'b1;
        no_cpu_code_i <= 1'b1;
        cyc(4);
        rd(REG_STATUS, st);
        chk("nocpu", 4, st[2:0]);
        chk("nocpu_ok", 0, ok_lvl);
        reset_i <= 1'b1;
        no_cpu_code_i <= 1'b0;
        cyc(2);
        chk("por_off", 1, drives_off_o);
        reset_i <= 1'b0;
        cyc(1);
        rd(REG_STATUS, st);
        chk("por_clr", 1, st[2:0]);
        results();
    end
endmodule

// file: hdl/rfs_pkg.sv
// constants and types for the regulator fault supervisor
//
// Contract
// - soft-start: feedback above reference holds drives off
// - precharged above setpoint: drives wait for ramp end
// - ready low until soft-start end, delayed, window
// - ready low on faults or disable
// - overvoltage, overcurrent, no-cpu code latch off
// - undervoltage flag hysteresis only lowers ready
// - overvoltage level higher of fixed, setpoint plus; code: in soft-start only, setpoint plus alone after
// - overvoltage forces low sides until 110 mV drop
// - after overvoltage stay latched until reset; code: enable low also clears the latch
// - first soft-start overvoltage releases, second latches
// - averaged current above 100 uA trips overcurrent
// - transition raises averaged reference for 50 us
// - monitor voltage above reference trips overcurrent
// - overcurrent: drives off, ready low, retry
// - five overcurrents without success latch off
// - channel over limit: high off, low on
// - transition raises channel limit for 50 us
package rfs_pkg;
    // timing
    localparam int          CLK_MHZ         = 25;
    localparam int          BOOST_HOLD_US   = 50;
    localparam int          BOOST_HOLD_CYC  = BOOST_HOLD_US * CLK_MHZ;
    localparam int          RDY_DELAY_US    = 93;
    localparam int          RDY_DELAY_CYC   = RDY_DELAY_US * CLK_MHZ;
    localparam logic [2:0]  OC_RETRY_LIMIT  = 3'h5;
    localparam int          NUM_CH          = 3;

    // supervisor phases
    typedef enum logic [2:0] {
        RFS_OFF,
        RFS_START,
        RFS_RUN,
        RFS_OC_RETRY,
        RFS_LATCHED
    } rfs_phase_t;

    // analog comparator results
    typedef struct packed {
        logic       fb_above_ref;     // feedback above ramp reference
        logic       above_setpoint;   // output above final setpoint
        logic       ov_fixed;         // above fixed 1.280 V level
        logic       ov_dac;           // above setpoint plus 175 mV
        logic       ov_fixed_low;     // 110 mV below fixed level
        logic       ov_dac_low;       // 110 mV below setpoint level
        logic       uv_below_050;     // below half setpoint
        logic       uv_above_060;     // above 0.60 setpoint
        logic       iavg_100;         // averaged current over 100 uA
        logic       iavg_140;         // averaged current over 140 uA
        logic       current_monitor_voltage_over;        // monitor voltage over ref
    } rfs_sense_t;

    // per channel comparators
    typedef struct packed {
        logic [NUM_CH-1:0] over_140;  // channel over normal limit
        logic [NUM_CH-1:0] over_196;  // channel over boosted limit
    } rfs_chan_t;

    // gate drive overrides
    typedef struct packed {
        logic [NUM_CH-1:0] hs_block;  // force high side off
        logic [NUM_CH-1:0] ls_force;  // force low side on
    } rfs_drive_t;

    // whole module state
    typedef struct packed {
        rfs_phase_t  phase;
        logic        ov_active;       // low sides held for overvoltage
        logic        ov_in_ss;        // trip level used fixed
        logic        ss_ov_seen;      // one soft-start overvoltage
        logic [2:0]  oc_count;        // overcurrent retries
        logic        uv_flag;         // undervoltage flag
        logic [11:0] boost_cnt;       // boost hold countdown
        logic [11:0] rdy_cnt;         // ready delay countdown
        logic        ready;           // ready flag
        logic        retry_req;       // request new soft-start
        rfs_drive_t  drive;           // registered overrides
        logic        drive_off;       // both drives held off
        logic [3:0]  irq_status;      // sticky events
        logic [3:0]  irq_mask;        // enable mask
        logic [31:0] rdata;           // read data
    } rfs_state_t;

    // register offsets
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_IRQ    = 4'h4;
    localparam logic [3:0] REG_MASK   = 4'h8;
    // irq bit positions
    localparam int IRQ_OV   = 0;
    localparam int IRQ_OC   = 1;
    localparam int IRQ_UV   = 2;
    localparam int IRQ_LAT  = 3;
endpackage

// file: hdl/rfs_supervisor.sv
// fault and start-up supervisor for a three channel buck controller
`timescale 1ns/100ps
module rfs_supervisor
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    // enable and power state
    input  wire logic              enable_i,
    input  wire logic              no_cpu_code_i,
    input  wire logic              vid_transition_i,
    // soft-start ramp generator
    input  wire logic              ss_active_i,
    input  wire logic              ss_done_i,
    output      logic              ss_restart_o,
    // comparators
    input  wire rfs_pkg::rfs_sense_t sense_i,
    input  wire rfs_pkg::rfs_chan_t  chan_i,
    // gate drive overrides
    output      rfs_pkg::rfs_drive_t drive_o,
    output      logic              drives_off_o,
    // open-drain ready flag
    output      logic              regulator_ok_flag_o,
    output      logic              regulator_ok_flag_oe_o,
    // register port
    input  wire logic [3:0]        addr_i,
    input  wire logic [31:0]       wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output      logic [31:0]       rdata_o,
    output      logic              irq_o
);
    import rfs_pkg::*;

    // ****************************************
    // state
    // ****************************************
    rfs_state_t s;       // registered state
    rfs_state_t next_s;  // next state
    logic       boost;   // transition boost in force
    logic       ov_trip; // overvoltage comparator at active level
    logic       ov_low;  // output 110 mV below tripped level
    logic       oc_trip; // either overcurrent detector
    logic [NUM_CH-1:0] ch_over; // channel over its limit
    logic [3:0] events;  // new events this cycle

    // boost while moving and during hold
    always_comb
    begin
        boost = vid_transition_i || (s.boost_cnt != 12'h000);
    end

    // ****************************************
    // comparator selection
    // ****************************************
    always_comb
    begin
        if (ss_active_i)
        begin
            ov_trip = sense_i.ov_fixed && sense_i.ov_dac;
        end
        else
        begin
            ov_trip = sense_i.ov_dac;
        end
        ov_low = s.ov_in_ss ? (sense_i.ov_fixed_low && sense_i.ov_dac_low)
                            : sense_i.ov_dac_low;
        oc_trip = (boost ? sense_i.iavg_140 : sense_i.iavg_100)
                  || sense_i.current_monitor_voltage_over;
        ch_over = boost ? chan_i.over_196 : chan_i.over_140;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        next_s           = s;
        next_s.retry_req = 1'b0;
        next_s.rdata     = 32'h0000_0000;
        events           = 4'h0;

        // hold boost 50 us after transition
        if (vid_transition_i)
        begin
            next_s.boost_cnt = 12'(BOOST_HOLD_CYC);
        end
        else if (s.boost_cnt != 12'h000)
        begin
            next_s.boost_cnt = s.boost_cnt - 12'h001;
        end

        if (sense_i.uv_below_050)
        begin
            next_s.uv_flag = 1'b1;
        end
        else if (sense_i.uv_above_060)
        begin
            next_s.uv_flag = 1'b0;
        end
        if (sense_i.uv_below_050 && !s.uv_flag)
        begin
            events[IRQ_UV] = 1'b1;
        end

        if (ov_trip && !s.ov_active)
        begin
            next_s.ov_active = 1'b1;
            next_s.ov_in_ss  = ss_active_i;
            events[IRQ_OV]   = 1'b1;
        end
        else if (s.ov_active && ov_low)
        begin
            next_s.ov_active = 1'b0;
        end

        unique case (s.phase)
            RFS_OFF:
            begin
                next_s.ready = 1'b0;
                // a no-cpu code at enable latches off at once
                if (enable_i && no_cpu_code_i)
                begin
                    next_s.phase = RFS_LATCHED;
                end
                else if (enable_i)
                begin
                    next_s.phase     = RFS_START;
                    next_s.retry_req = 1'b1;
                end
            end
            RFS_START, RFS_RUN:
            begin
                // second soft-start overvoltage latches
                // a stale trip level must not decide the first soft-start trip
                if (ov_trip && !s.ov_active && ss_active_i && !s.ss_ov_seen)
                begin
                    next_s.ss_ov_seen = 1'b1;
                end
                else if (ov_trip && !s.ov_active)
                begin
                    next_s.phase = RFS_LATCHED;
                end
                if (no_cpu_code_i)
                begin
                    next_s.phase = RFS_LATCHED;
                end
                else if (oc_trip)
                begin
                    events[IRQ_OC]  = 1'b1;
                    next_s.oc_count = s.oc_count + 3'h1;
                    if (s.oc_count + 3'h1 >= OC_RETRY_LIMIT)
                    begin
                        next_s.phase = RFS_LATCHED;
                    end
                    else
                    begin
                        next_s.phase = RFS_OC_RETRY;
                    end
                end
                else if (s.phase == RFS_START && ss_done_i)
                begin
                    next_s.phase    = RFS_RUN;
                    next_s.oc_count = 3'h0;
                    next_s.rdy_cnt  = 12'(RDY_DELAY_CYC);
                end
                if (s.phase == RFS_RUN && s.rdy_cnt != 12'h000)
                begin
                    next_s.rdy_cnt = s.rdy_cnt - 12'h001;
                end
                next_s.ready = (s.phase == RFS_RUN)
                               && (s.rdy_cnt == 12'h000)
                               && !next_s.uv_flag && !ov_trip
                               && !next_s.ov_active && !oc_trip
                               && !no_cpu_code_i;
            end
            RFS_OC_RETRY:
            begin
                next_s.ready     = 1'b0;
                next_s.phase     = RFS_START;
                next_s.retry_req = 1'b1;
            end
            RFS_LATCHED:
            begin
                next_s.ready = 1'b0;
            end
        endcase
        if (next_s.phase == RFS_LATCHED && s.phase != RFS_LATCHED)
        begin
            events[IRQ_LAT] = 1'b1;
        end

        // enable low clears latch, retry count and soft-start overvoltage flag
        if (!enable_i)
        begin
            next_s.phase      = RFS_OFF;
            next_s.oc_count   = 3'h0;
            next_s.ss_ov_seen = 1'b0;
            next_s.ready      = 1'b0;
        end

        next_s.drive_off = (next_s.phase != RFS_START
                            && next_s.phase != RFS_RUN)
                           || oc_trip
                           || (ss_active_i && sense_i.fb_above_ref)
                           || (ss_active_i && sense_i.above_setpoint);
        for (int i = 0; i < NUM_CH; i++)
        begin
            next_s.drive.ls_force[i] = next_s.ov_active || ch_over[i];
            next_s.drive.hs_block[i] = next_s.ov_active || ch_over[i];
        end

        // interrupt status: set wins over clear
        if (wr_i && addr_i == REG_IRQ)
        begin
            next_s.irq_status = s.irq_status & ~wdata_i[3:0];
        end
        if (wr_i && addr_i == REG_MASK)
        begin
            next_s.irq_mask = wdata_i[3:0];
        end
        next_s.irq_status = next_s.irq_status | events;

        // read data one cycle later
        if (rd_i)
        begin
            unique case (addr_i)
                REG_STATUS: next_s.rdata = {22'h00_0000, s.oc_count,
                                            s.uv_flag, s.ov_active,
                                            s.ready, 1'b0, s.phase};
                REG_IRQ:    next_s.rdata = {28'h000_0000, s.irq_status};
                REG_MASK:   next_s.rdata = {28'h000_0000, s.irq_mask};
                default:    next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s <= '{phase: RFS_OFF, drive_off: 1'b1, default: '0};
        end
        else
        begin
            s <= next_s;
        end
    end

    // outputs
    assign drive_o                = s.drive;
    assign drives_off_o           = s.drive_off;
    assign ss_restart_o           = s.retry_req;
    assign regulator_ok_flag_o    = 1'b0;
    assign regulator_ok_flag_oe_o = !s.ready;
    assign rdata_o                = s.rdata;
    assign irq_o                  = |(s.irq_status & s.irq_mask);

    // ****************************************
    // checks
    // ****************************************
    chk_ready_off_state: assert property (@(posedge clk_i)
        disable iff (reset_i) !enable_i |=> !s.ready)
        else $error("ready high after disable");
    chk_ov_forces_low: assert property (@(posedge clk_i)
        disable iff (reset_i) s.ov_active |-> &s.drive.ls_force)
        else $error("low sides not forced on overvoltage");
    chk_latch_holds: assert property (@(posedge clk_i)
        disable iff (reset_i)
        (s.phase == RFS_LATCHED && enable_i) |=> s.phase == RFS_LATCHED)
        else $error("latch released without enable");
    chk_oc_count_max: assert property (@(posedge clk_i)
        disable iff (reset_i) s.oc_count <= OC_RETRY_LIMIT)
        else $error("retry count beyond limit");
    chk_uv_ready_low: assert property (@(posedge clk_i)
        disable iff (reset_i) s.uv_flag |-> !s.ready)
        else $error("ready high in undervoltage");
    chk_start_no_ready: assert property (@(posedge clk_i)
        disable iff (reset_i) s.phase == RFS_START |-> !s.ready)
        else $error("ready before soft-start end");
    chk_oc_drives_off: assert property (@(posedge clk_i)
        disable iff (reset_i) oc_trip |=> s.drive_off)
        else $error("drives on during overcurrent");
    chk_chan_limit: assert property (@(posedge clk_i)
        disable iff (reset_i) ch_over[0] |=> s.drive.hs_block[0])
        else $error("channel high side not blocked");
endmodule
